/* File: core/imp_ctrl.sv */
// Added by the designer: the APB register port.
`timescale 1ns/100ps
module imp_ctrl
   import imp_pkg::*;
(
   input  wire logic              i_clk,
   input  wire logic              i_rst,
   input  wire logic              i_psel,
   input  wire logic              i_penable,
   input  wire logic              i_pwrite,
   input  wire logic [12:0]       i_paddr,
   input  wire logic [31:0]       i_pwdata,
   output logic                   o_pready,
   output logic [31:0]            o_prdata,
   output logic                   o_pslverr,
   input  wire logic [15:0]       i_level_req,
   input  wire logic [7:0]        i_edge_req,
   output imp_core_req_t          o_core_req
);

   logic [23:0]  enable;
   logic         global_en;
   logic [23:0]  prio;
   logic [15:0]  level_flag;
   logic [7:0]   edge_flag;
   logic [7:0]   edge_prev;
   logic [15:0]  lvl_s1;
   logic [15:0]  lvl_s2;
   logic [15:0]  lvl_s3;
   logic [7:0]   edg_s1;
   logic [7:0]   edg_s2;
   logic [7:0]   edg_s3;
   logic [7:0]   edge_clr;
   logic [7:0]   edge_rise;
   logic         wr_acc;
   logic         rd_acc;
   logic         sel_ok;
   logic [23:0]  active;
   logic [23:0]  active_hi;
   logic [7:0]   rd_byte;
   imp_core_req_t next_core;

   function automatic logic [4:0] lowest_set(input logic [23:0] v);
      logic [4:0] r;
      r = 5'h00;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = 5'(i);
         end
      end
      return r;
   endfunction

   // One register per word: the highest byte address needs thirteen bits
   function automatic logic [12:0] byte_addr(input logic [11:0] off);
      return 13'(off) << ADDR_SHIFT;
   endfunction

   function automatic logic hit(input logic [12:0] a, input logic [11:0] off);
      return a == byte_addr(off);
   endfunction

   // Peripheral lines come from other logic; synchronised conservatively
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         lvl_s1 <= 16'h0000;
         lvl_s2 <= 16'h0000;
         lvl_s3 <= 16'h0000;
         edg_s1 <= 8'h00;
         edg_s2 <= 8'h00;
         edg_s3 <= 8'h00;
      end else begin
         lvl_s1 <= i_level_req;
         lvl_s2 <= lvl_s1;
         lvl_s3 <= lvl_s2;
         edg_s1 <= i_edge_req & EDGE_RSV_MASK;
         edg_s2 <= edg_s1;
         edg_s3 <= edg_s2;
      end
   end

   assign wr_acc = i_psel && i_penable && i_pwrite;
   assign rd_acc = i_psel && !i_pwrite;
   assign edge_clr = (wr_acc && hit(i_paddr, OFF_FLAGE)) ? i_pwdata[7:0] : 8'h00;
   assign edge_rise = edg_s2 & edg_s3 & ~edge_prev;

   // Enable, control and priority bytes
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         enable    <= RESET_VEC;
         global_en <= 1'b0;
         prio      <= RESET_VEC;
      end else if (wr_acc) begin
         if (hit(i_paddr, OFF_EN_LO)) begin
            enable[7:0] <= i_pwdata[7:0];
         end
         if (hit(i_paddr, OFF_EN_HI)) begin
            enable[15:8] <= i_pwdata[7:0];
         end
         if (hit(i_paddr, OFF_EN_EDGE)) begin
            enable[23:16] <= i_pwdata[7:0] & EDGE_RSV_MASK;
         end
         if (hit(i_paddr, OFF_GCTRL)) begin
            // Bit one is reserved and not stored
            global_en <= i_pwdata[GCTRL_EN_BIT];
         end
         if (hit(i_paddr, OFF_PRIO0)) begin
            prio[7:0] <= i_pwdata[7:0];
         end
         if (hit(i_paddr, OFF_PRIO1)) begin
            prio[15:8] <= i_pwdata[7:0];
         end
         if (hit(i_paddr, OFF_PRIO2)) begin
            prio[23:16] <= i_pwdata[7:0] & EDGE_RSV_MASK;
         end
      end
   end

   // Level flags follow the peripheral line once two stages agree
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         level_flag <= 16'h0000;
      end else begin
         for (int i = 0; i < NUM_LEVEL; i++) begin
            if (lvl_s2[i] == lvl_s3[i]) begin
               level_flag[i] <= lvl_s3[i];
            end
         end
      end
   end

   // Edge flags: a new rising edge wins over a same-cycle clear
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         edge_flag <= 8'h00;
         edge_prev <= 8'h00;
      end else begin
         for (int i = 0; i < NUM_EDGE; i++) begin
            if (edg_s2[i] == edg_s3[i]) begin
               edge_prev[i] <= edg_s3[i];
            end
         end
         edge_flag <= (edge_flag & ~edge_clr) | edge_rise;
      end
   end

   assign active    = {edge_flag, level_flag} & enable & {NUM_SRC{global_en}};
   assign active_hi = active & prio;

   always_comb begin
      next_core.req  = |active;
      next_core.high = |active_hi;
      if (|active_hi) begin
         next_core.id = lowest_set(active_hi);
      end else begin
         next_core.id = lowest_set(active);
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_core_req <= '0;
      end else begin
         o_core_req <= next_core;
      end
   end

   always_comb begin
      rd_byte = 8'h00;
      sel_ok  = 1'b1;
      unique case (i_paddr)
         byte_addr(OFF_EN_LO):   rd_byte = enable[7:0];
         byte_addr(OFF_EN_HI):   rd_byte = enable[15:8];
         byte_addr(OFF_EN_EDGE): rd_byte = enable[23:16];
         byte_addr(OFF_GCTRL):   rd_byte = {7'h00, global_en};
         byte_addr(OFF_PRIO0):   rd_byte = prio[7:0];
         byte_addr(OFF_PRIO1):   rd_byte = prio[15:8];
         byte_addr(OFF_PRIO2):   rd_byte = prio[23:16];
         byte_addr(OFF_FLAG0):   rd_byte = level_flag[7:0];
         byte_addr(OFF_FLAG1):   rd_byte = level_flag[15:8];
         byte_addr(OFF_FLAGE):   rd_byte = edge_flag;
         default:                   sel_ok = 1'b0;
      endcase
   end

   // Zero-wait slave: ready rises in the first access cycle
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_pready  <= 1'b0;
         o_prdata  <= 32'h00000000;
         o_pslverr <= 1'b0;
      end else begin
         o_pready  <= i_psel && !i_penable;
         o_pslverr <= i_psel && !i_penable && !sel_ok;
         if (rd_acc && !i_penable) begin
            o_prdata <= {24'h000000, rd_byte};
         end
      end
   end

   a_req_masked_off: assert property (@(posedge i_clk) disable iff (i_rst)
      !global_en |=> !o_core_req.req)
      else $error("core request with global enable low");

   a_req_follows_flags: assert property (@(posedge i_clk) disable iff (i_rst)
      (|({edge_flag, level_flag} & enable) && global_en) |=> o_core_req.req)
      else $error("enabled pending flag not requested");

   a_edge_flag_hold: assert property (@(posedge i_clk) disable iff (i_rst)
      (edge_flag[0] && !edge_clr[0]) |=> edge_flag[0])
      else $error("edge flag dropped without clear");

   a_edge_clear_works: assert property (@(posedge i_clk) disable iff (i_rst)
      (edge_clr[0] && !edge_rise[0]) |=> !edge_flag[0])
      else $error("edge flag not cleared by write one");

   a_edge_set_wins: assert property (@(posedge i_clk) disable iff (i_rst)
      edge_rise[0] |=> edge_flag[0])
      else $error("rising edge lost");

   a_level_follow: assert property (@(posedge i_clk) disable iff (i_rst)
      (lvl_s2[0] && lvl_s3[0]) |=> level_flag[0])
      else $error("level flag not following input");

   a_high_first: assert property (@(posedge i_clk) disable iff (i_rst)
      (|active_hi) |=> (o_core_req.high && prio[o_core_req.id]))
      else $error("low priority presented over high");

   a_mask_blocks: assert property (@(posedge i_clk) disable iff (i_rst)
      (enable == 24'h000000 && $stable(enable)) |=> !o_core_req.req)
      else $error("masked source requested core");

   a_ready_one_cycle: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_psel && !i_penable) |=> o_pready ##1 !o_pready)
      else $error("pready not a single-cycle answer");

   // Bus answer: ready and error belong to the access phase only
   a_pslverr_ready: assert property (@(posedge i_clk) disable iff (i_rst)
      o_pslverr |-> o_pready)
      else $error("slave error without ready");

   a_ready_in_access: assert property (@(posedge i_clk) disable iff (i_rst)
      o_pready |-> (i_psel && i_penable))
      else $error("ready outside access phase");

   a_idle_no_ready: assert property (@(posedge i_clk) disable iff (i_rst)
      !i_psel |=> !o_pready)
      else $error("ready without a selected transfer");

   a_unmapped_err: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_psel && !i_penable && !sel_ok) |=> o_pslverr)
      else $error("unmapped address not flagged");

   // Read data is loaded at the setup edge, so it is held against the state one edge back
   a_gctrl_rsv_read: assert property (@(posedge i_clk) disable iff (i_rst)
      (rd_acc && !i_penable && hit(i_paddr, OFF_GCTRL)) |=> !o_prdata[GCTRL_RSV_BIT])
      else $error("reserved control bit reads one");

   a_flag_read_lvl0: assert property (@(posedge i_clk) disable iff (i_rst)
      (rd_acc && !i_penable && hit(i_paddr, OFF_FLAG0)) |=> (o_prdata[7:0] == 8'($past(level_flag))))
      else $error("first flag byte read wrong");

   a_flag_read_lvl1: assert property (@(posedge i_clk) disable iff (i_rst)
      (rd_acc && !i_penable && hit(i_paddr, OFF_FLAG1)) |=> (o_prdata[7:0] == 8'($past(level_flag) >> 8)))
      else $error("second flag byte read wrong");

   a_flag_read_edge: assert property (@(posedge i_clk) disable iff (i_rst)
      (rd_acc && !i_penable && hit(i_paddr, OFF_FLAGE)) |=> (o_prdata[7:0] == $past(edge_flag)))
      else $error("edge flag byte read wrong");

   // Software may read late, so read data must not drift between reads
   a_prdata_holds: assert property (@(posedge i_clk) disable iff (i_rst)
      !(rd_acc && !i_penable) |=> $stable(o_prdata))
      else $error("read data changed without a read");

   // Request output against flags, enables and priority
   a_req_needs_enable: assert property (@(posedge i_clk) disable iff (i_rst)
      !(|({edge_flag, level_flag} & enable)) |=> !o_core_req.req)
      else $error("request with no enabled flag");

   a_req_needs_global: assert property (@(posedge i_clk) disable iff (i_rst)
      o_core_req.req |-> $past(global_en))
      else $error("request raised while globally disabled");

   a_high_needs_req: assert property (@(posedge i_clk) disable iff (i_rst)
      o_core_req.high |-> o_core_req.req)
      else $error("high priority marked without request");

   a_low_pick: assert property (@(posedge i_clk) disable iff (i_rst)
      ((|active) && !(|active_hi)) |=> !o_core_req.high)
      else $error("low priority request marked high");

   a_id_in_range: assert property (@(posedge i_clk) disable iff (i_rst)
      o_core_req.id <= 5'h17)
      else $error("source number beyond last source");

   // Flag storage
   a_level_drop: assert property (@(posedge i_clk) disable iff (i_rst)
      (!lvl_s2[0] && !lvl_s3[0]) |=> !level_flag[0])
      else $error("level flag stuck after input fell");

   a_level_hold: assert property (@(posedge i_clk) disable iff (i_rst)
      (lvl_s2[0] != lvl_s3[0]) |=> $stable(level_flag[0]))
      else $error("level flag moved before stages agreed");

   a_edge_no_self: assert property (@(posedge i_clk) disable iff (i_rst)
      (!edge_flag[0] && !edge_rise[0]) |=> !edge_flag[0])
      else $error("edge flag set without rising edge");

   a_edge_rise_once: assert property (@(posedge i_clk) disable iff (i_rst)
      edge_rise[0] |=> !edge_rise[0])
      else $error("one rising edge detected twice");

   a_edge_clear_bit2: assert property (@(posedge i_clk) disable iff (i_rst)
      (edge_clr[2] && !edge_rise[2]) |=> !edge_flag[2])
      else $error("pin edge flag not cleared by write one");

   a_edge_rsv_idle: assert property (@(posedge i_clk) disable iff (i_rst)
      !edge_flag[7] && !enable[23] && !prio[23])
      else $error("reserved edge bit holds a one");
endmodule

/* File: core/imp_pkg.sv */
package imp_pkg;
   localparam int unsigned NUM_SRC   = 24;
   localparam int unsigned NUM_LEVEL = 16;
   localparam int unsigned NUM_EDGE  = 8;
   // Word indices of the register window; byte_addr scales them to byte addresses
   localparam logic [11:0] OFF_EN_LO   = 12'h640;
   localparam logic [11:0] OFF_EN_HI   = 12'h641;
   localparam logic [11:0] OFF_EN_EDGE = 12'h642;
   localparam logic [11:0] OFF_GCTRL   = 12'h643;
   localparam logic [11:0] OFF_PRIO0   = 12'h644;
   localparam logic [11:0] OFF_PRIO1   = 12'h645;
   localparam logic [11:0] OFF_PRIO2   = 12'h646;
   localparam logic [11:0] OFF_FLAG0   = 12'h648;
   localparam logic [11:0] OFF_FLAG1   = 12'h649;
   localparam logic [11:0] OFF_FLAGE   = 12'h64A;
   // Offsets are word indices, not byte addresses: byte address is index times four
   localparam int unsigned ADDR_SHIFT  = 2;
   localparam int unsigned GCTRL_EN_BIT = 0;
   localparam int unsigned GCTRL_RSV_BIT = 1;
   localparam logic [7:0]  EDGE_RSV_MASK = 8'h7F;
   localparam logic [7:0]  RESET_BYTE  = 8'h00;
   localparam logic [23:0] RESET_VEC   = 24'h000000;

   typedef struct packed {
      logic        req;
      logic        high;
      logic [4:0]  id;
   } imp_core_req_t;
endpackage

/* File: test/imp_src_model.sv */
`timescale 1ns/100ps
module imp_src_model (
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic [15:0] i_raise,
   input  wire logic [15:0] i_retire,
   input  wire logic [7:0]  i_fire,
   output logic      [15:0] o_level_req,
   output logic      [7:0]  o_edge_req
);
   // A peripheral holds its level request until software retires its own status
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_level_req <= 16'h0000;
      end else begin
         o_level_req <= (o_level_req | i_raise) & ~i_retire;
      end
   end
   // Event lines only pulse; nothing sits behind bit seven
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_edge_req <= 8'h00;
      end else begin
         o_edge_req <= i_fire & 8'h7F;
      end
   end
endmodule

/* File: test/irq_mask_priority_flags_bench.sv */
`timescale 1ns/100ps
module irq_mask_priority_flags_bench
   import imp_pkg::*;
;
   logic          i_clk = 1'b0;
   logic          i_rst = 1'b1;
   logic          i_psel = 1'b0;
   logic          i_penable = 1'b0;
   logic          i_pwrite = 1'b0;
   logic [12:0]   i_paddr = 13'h0000;
   logic [31:0]   i_pwdata = 32'h00000000;
   logic          o_pready;
   logic [31:0]   o_prdata;
   logic          o_pslverr;
   logic [15:0]   lvl_req;
   logic [7:0]    edg_req;
   logic [15:0]   raise = 16'h0000;
   logic [15:0]   retire = 16'h0000;
   logic [7:0]    fire = 8'h00;
   imp_core_req_t o_core_req;
   int            err_count = 0;
   int            checks = 0;
   logic [31:0]   rd;
   logic          er;
   logic [11:0]   offs [10] = '{OFF_EN_LO, OFF_EN_HI, OFF_EN_EDGE, OFF_GCTRL, OFF_PRIO0, OFF_PRIO1,
                                OFF_PRIO2, OFF_FLAG0, OFF_FLAG1, OFF_FLAGE};
   logic [7:0]    rbm [7] = '{8'hFF, 8'hFF, EDGE_RSV_MASK, 8'h01, 8'hFF, 8'hFF, EDGE_RSV_MASK};

   always #2 i_clk = ~i_clk;

   imp_ctrl u_imp_ctrl (.i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
      .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
      .o_prdata(o_prdata), .o_pslverr(o_pslverr), .i_level_req(lvl_req), .i_edge_req(edg_req),
      .o_core_req(o_core_req));
   imp_src_model u_imp_src_model (.i_clk(i_clk), .i_rst(i_rst), .i_raise(raise), .i_retire(retire),
      .i_fire(fire), .o_level_req(lvl_req), .o_edge_req(edg_req));

   task automatic give_verdict;
      if (err_count == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Holds the request until pready is seen at a rising edge; data taken at that edge
   task automatic apb(input logic wr, input logic [11:0] off, input logic [7:0] wd);
      int n;
      @(posedge i_clk);
      i_psel <= 1'b1;
      i_penable <= 1'b0;
      i_pwrite <= wr;
      i_paddr <= 13'(off) << ADDR_SHIFT;
      i_pwdata <= {24'h000000, wd};
      @(posedge i_clk);
      i_penable <= 1'b1;
      n = 0;
      do begin
         @(posedge i_clk);
         n++;
      end while (o_pready !== 1'b1 && n < 50);
      if (o_pready !== 1'b1) err_count++;
      rd = o_prdata;
      er = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask
   task automatic rdchk(input string name, input logic [11:0] off, input logic [7:0] exp);
      apb(1'b0, off, 8'h00);
      check(name, rd, {24'h000000, exp});
      check({name, "_slverr"}, {31'h0, er}, 32'h00000000);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   task automatic core(input string name, input logic [6:0] exp);
      check(name, {25'h0, o_core_req}, {25'h0, exp});
   endtask

   initial begin
      repeat (5000) @(posedge i_clk);
      err_count++;
      give_verdict();
   end

   initial begin
      repeat (12) @(posedge i_clk);
      i_rst <= 1'b0;
      for (int k = 0; k < 10; k++) rdchk("reset_value", offs[k], RESET_BYTE);
      core("reset_core", 7'h00);
      for (int k = 0; k < 7; k++) apb(1'b1, offs[k], 8'hFF);
      for (int k = 0; k < 7; k++) rdchk("readback", offs[k], rbm[k]);
      apb(1'b0, 12'h647, 8'h00);
      check("unmapped_data", rd, 32'h00000000);
      check("unmapped_slverr", {31'h0, er}, 32'h00000001);
      for (int k = 0; k < 7; k++) apb(1'b1, offs[k], 8'h00);
      raise <= 16'h0001;
      idle(1);
      raise <= 16'h0000;
      idle(8);
      rdchk("level_flag", OFF_FLAG0, 8'h01);
      core("masked_source", 7'h00);
      apb(1'b1, OFF_EN_LO, 8'h01);
      idle(4);
      core("global_off", 7'h00);
      apb(1'b1, OFF_GCTRL, 8'h01);
      idle(4);
      core("level_request", 7'h40);
      apb(1'b1, OFF_FLAG0, 8'h01);
      rdchk("level_not_cleared", OFF_FLAG0, 8'h01);
      apb(1'b1, OFF_EN_EDGE, 8'h05);
      fire <= 8'h05;
      idle(3);
      fire <= 8'h00;
      idle(8);
      rdchk("edge_latched", OFF_FLAGE, 8'h05);
      core("low_priority_pick", 7'h40);
      apb(1'b1, OFF_PRIO2, 8'h04);
      idle(4);
      core("high_priority_pick", 7'h72);
      apb(1'b1, OFF_FLAGE, 8'h04);
      idle(4);
      rdchk("edge_cleared", OFF_FLAGE, 8'h01);
      retire <= 16'h0001;
      idle(1);
      retire <= 16'h0000;
      idle(8);
      rdchk("level_retired", OFF_FLAG0, 8'h00);
      core("edge_only", 7'h50);
      apb(1'b1, OFF_GCTRL, 8'h00);
      idle(4);
      core("global_cleared", 7'h00);
      apb(1'b1, OFF_FLAGE, 8'h01);
      rdchk("edge_all_cleared", OFF_FLAGE, 8'h00);
      apb(1'b1, OFF_PRIO2, RESET_BYTE);
      rdchk("prio_restored", OFF_PRIO2, RESET_BYTE);
      give_verdict();
   end
endmodule
